//--- sim/pcrc_top_properties.sv
/*
 Port checks for the programmable CRC generator top.
 Assumes it is bound into pcrc_top, one clock pclk, async reset presetn.
*/
`timescale 1ns/1ps
`default_nettype none

module pcrc_top_properties #(
    parameter int FIFO_DEPTH = 16,
    parameter int FIFO_DEPTH_LONG = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic idle_mode,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Event
    input wire logic crc_irq
);
    // ==========================================================
    // Common timing
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire logic rd_ok = pready && !pwrite && !pslverr;

    // ==========================================================
    // Bus answer
    AST_READY_ANSWER: assert property (psel && !penable && clk_en |-> ##1 pready)
        else $error("no ready one cycle after setup");
    AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    AST_READY_CAUSE: assert property (pready |-> $past(psel && !penable))
        else $error("ready without a setup cycle");
    AST_UNMAPPED: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h14))
        else $error("slave error does not match the address map");
    AST_ERR_NO_DATA: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
        else $error("read data on an error answer");

    // ==========================================================
    // Register contents and interrupt pulse
    AST_LOW_TERM_ZERO: assert property (rd_ok && paddr == 8'h0c |-> prdata[0] == 1'b0 && prdata[31:16] == 16'h0000)
        else $error("lowest polynomial bit reads one");
    AST_CTRL2_UNUSED: assert property (rd_ok && paddr == 8'h04 |-> prdata[31:13] == 19'h0 && prdata[7:5] == 3'h0)
        else $error("unused bits of the second control register set");
    AST_EMPTY_FLAG: assert property (rd_ok && paddr == 8'h00 |-> prdata[6] == (prdata[12:8] == 5'h00))
        else $error("empty flag does not match the word count");
    AST_COUNT_CAP: assert property (rd_ok && paddr == 8'h00 |-> prdata[12:8] <= FIFO_DEPTH)
        else $error("word count above fifo size");
    AST_FULL_FLAG: assert property (rd_ok && paddr == 8'h00 && prdata[7] |-> prdata[12:8] >= FIFO_DEPTH_LONG)
        else $error("full flag with too few words");
    AST_IRQ_PULSE: assert property ($rose(crc_irq) |=> $fell(crc_irq))
        else $error("interrupt longer than one cycle");
endmodule // pcrc_top_properties

bind pcrc_top pcrc_top_properties #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_DEPTH_LONG(FIFO_DEPTH_LONG)) i_props (
    .pclk, .presetn, .clk_en, .idle_mode, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .crc_irq
);

`default_nettype wire

//--- sim/tb_top.sv
/*
 Self-checking testbench of the programmable CRC generator over APB.
 Assumes pcrc_map.svh on the include path and the checker bound to pcrc_top.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcrc_map.svh"

module tb_top;
    import pcrc_pkg::*;
    // ==========================================================
    // Signals and design
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic idle_mode = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic crc_irq;
    int fails = 0;
    int n_tests = 0;
    int plen, dw, cap, k;
    logic lsb, ev;
    pcrc_word_t exp_crc, w, ctl, poly, rv;

    always #12.5 pclk = ~pclk;

    pcrc_top i_dut (
        .pclk, .presetn, .clk_en, .idle_mode, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .crc_irq
    );

    // ==========================================================
    // Checking and bus tasks
    task automatic test_done;
        if (fails == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask

    // One serial step of the reference shift register
    function automatic pcrc_word_t crc_step(pcrc_word_t cur, logic b, int pl, pcrc_word_t pv);
        pcrc_word_t nw;
        logic fb;
        fb = b ^ cur[pl];
        nw = 32'h0;
        nw[0] = fb;
        for (int i = 1; i <= pl; i++) begin
            nw[i] = cur[i-1] ^ (fb & pv[i]);
        end
        return nw;
    endfunction

    // ==========================================================
    // Watchdog
    initial begin
        #500000;
        fails++;
        test_done;
    end

    // ==========================================================
    // Tests
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 24; a += 4) rdc(8'(a), (a == 0) ? 32'h40 : 32'h0);
        wr(`PCRC_OFS_CONTROL_TWO, 32'hffff_ffff);
        rdc(`PCRC_OFS_CONTROL_TWO, 32'h1f1f);
        wr(`PCRC_OFS_POLY_HIGH, 32'hffff_ffff);
        rdc(`PCRC_OFS_POLY_HIGH, 32'hffff);
        wr(`PCRC_OFS_POLY_LOW, 32'hffff_ffff);
        rdc(`PCRC_OFS_POLY_LOW, 32'hfffe);
        wr(`PCRC_OFS_CONTROL_ONE, 32'hffff_ffff);
        rdc(`PCRC_OFS_CONTROL_ONE, 32'ha078);
        apb(1'b1, 8'h18, 32'h1, rv, ev);
        chk({31'h0, ev}, 32'h1);
        apb(1'b0, 8'h40, 32'h0, rv, ev);
        chk({31'h0, ev}, 32'h1);
        // Short and long polynomial, both shift orders and both interrupt events
        for (int c = 0; c < 2; c++) begin
            plen = c ? 31 : 7;
            dw = c ? 31 : 7;
            cap = c ? 8 : 16;
            lsb = (c == 1);
            poly = c ? 32'h04c1_1db7 : 32'h0000_0007;
            ctl = c ? 32'h8028 : 32'h8000;
            wr(`PCRC_OFS_CONTROL_ONE, ctl);
            wr(`PCRC_OFS_CONTROL_TWO, 32'((dw << 8) | plen));
            wr(`PCRC_OFS_POLY_HIGH, poly >> 16);
            wr(`PCRC_OFS_POLY_LOW, poly & 32'hffff);
            rdc(`PCRC_OFS_POLY_LOW, poly & 32'hfffe);
            wr(`PCRC_OFS_RESULT, 32'hffff_ffff);
            exp_crc = 32'hffff_ffff;
            for (int i = 0; i <= cap; i++) begin
                w = 32'h9e37_79b9 * (i + 3);
                wr(`PCRC_OFS_DATA_INPUT, w);
                for (int j = 0; j <= dw && i < cap; j++) begin
                    exp_crc = crc_step(exp_crc, w[lsb ? j : dw - j], plen, poly);
                end
            end
            rdc(`PCRC_OFS_CONTROL_ONE, ctl | 32'(cap << 8) | 32'h80);
            wr(`PCRC_OFS_CONTROL_ONE, ctl | 32'h10);
            k = 0;
            while (crc_irq !== 1'b1 && k < 3000) begin
                @(posedge pclk);
                k++;
            end
            chk(32'(k < 3000), 32'h1);
            repeat (dw + 3) @(posedge pclk);
            rdc(`PCRC_OFS_RESULT, exp_crc);
            rdc(`PCRC_OFS_CONTROL_ONE, ctl | 32'h50);
        end
        wr(`PCRC_OFS_CONTROL_ONE, 32'h8000);
        wr(`PCRC_OFS_DATA_INPUT, 32'h1);
        wr(`PCRC_OFS_DATA_INPUT, 32'h2);
        rdc(`PCRC_OFS_CONTROL_ONE, 32'h8200);
        wr(`PCRC_OFS_CONTROL_ONE, 32'h0);
        rdc(`PCRC_OFS_CONTROL_ONE, 32'h40);
        rdc(`PCRC_OFS_RESULT, 32'h0);
        rdc(`PCRC_OFS_CONTROL_TWO, 32'h1f1f);
        rdc(`PCRC_OFS_POLY_HIGH, 32'h04c1);
        // Pushes are halted in idle only while stop-in-idle is set
        wr(`PCRC_OFS_CONTROL_ONE, 32'ha000);
        idle_mode <= 1'b1;
        wr(`PCRC_OFS_DATA_INPUT, 32'h3);
        rdc(`PCRC_OFS_CONTROL_ONE, 32'ha040);
        idle_mode <= 1'b0;
        wr(`PCRC_OFS_DATA_INPUT, 32'h4);
        rdc(`PCRC_OFS_CONTROL_ONE, 32'ha100);
        wr(`PCRC_OFS_CONTROL_ONE, 32'h8000);
        idle_mode <= 1'b1;
        wr(`PCRC_OFS_DATA_INPUT, 32'h5);
        rdc(`PCRC_OFS_CONTROL_ONE, 32'h8200);
        test_done;
    end
endmodule // tb_top

`default_nettype wire

//--- verilog/pcrc_fifo.sv
/*
 Data FIFO of the CRC generator: word store with count, full and empty.
 Pops when empty and pushes when full are both dropped here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcrc_map.svh"

module pcrc_fifo
    import pcrc_pkg::*;
#(
    parameter int DEPTH = `PCRC_FIFO_DEPTH,
    parameter int DEPTH_LONG = `PCRC_FIFO_DEPTH_LONG
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Engine side
    pcrc_fifo_if.store fifo
);
    localparam int AW = $clog2(DEPTH);
    localparam pcrc_field5_t CAP_FULL = 5'(DEPTH);
    localparam pcrc_field5_t CAP_LONG = 5'(DEPTH_LONG);

    pcrc_word_t mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    pcrc_field5_t count_reg;
    pcrc_field5_t cap;
    logic do_push;
    logic do_pop;

    assign cap = fifo.cap_short ? CAP_FULL : CAP_LONG;
    assign fifo.full = (count_reg >= cap);
    assign fifo.empty = (count_reg == 5'h00);
    assign fifo.count = count_reg;
    assign fifo.pop_data = mem[rd_ptr_reg];
    assign do_push = fifo.push && !fifo.full;
    assign do_pop = fifo.pop && !fifo.empty;

    // ==========================================================
    // Word store
    always_ff @(posedge pclk) begin
        if (clk_en && do_push) begin
            mem[wr_ptr_reg] <= fifo.push_data;
        end
    end

    // ==========================================================
    // Pointers and fill count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= `PCRC_RST_FIELD5;
        end else if (clk_en) begin
            if (fifo.flush) begin
                wr_ptr_reg <= '0;
                rd_ptr_reg <= '0;
                count_reg <= `PCRC_RST_FIELD5;
            end else begin
                if (do_push) begin
                    wr_ptr_reg <= wr_ptr_reg + 1'b1;
                end
                if (do_pop) begin
                    rd_ptr_reg <= rd_ptr_reg + 1'b1;
                end
                if (do_push && !do_pop) begin
                    count_reg <= count_reg + 5'h01;
                end else if (do_pop && !do_push) begin
                    count_reg <= count_reg - 5'h01;
                end
            end
        end
    end
endmodule // pcrc_fifo

`default_nettype wire

//--- verilog/pcrc_fifo_if.sv
/*
 Carrier between the CRC shift engine and its data FIFO.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface pcrc_fifo_if;
    import pcrc_pkg::*;
    logic push;
    pcrc_word_t push_data;
    logic pop;
    pcrc_word_t pop_data;
    logic flush;
    logic cap_short;
    pcrc_field5_t count;
    logic full;
    logic empty;

    modport engine (output push, push_data, pop, flush, cap_short, input pop_data, count, full, empty);
    modport store (input push, push_data, pop, flush, cap_short, output pop_data, count, full, empty);
endinterface

`default_nettype wire

//--- verilog/pcrc_map.svh
/*
 Register offsets, field positions, reset values and sizes of the
 programmable CRC generator.
 Assumes byte addressing on a 32-bit APB with one register per aligned word.
*/
`ifndef PCRC_MAP_SVH
`define PCRC_MAP_SVH

// ==========================================================
// Register byte offsets
`define PCRC_OFS_CONTROL_ONE 8'h00
`define PCRC_OFS_CONTROL_TWO 8'h04
`define PCRC_OFS_POLY_HIGH 8'h08
`define PCRC_OFS_POLY_LOW 8'h0c
`define PCRC_OFS_DATA_INPUT 8'h10
`define PCRC_OFS_RESULT 8'h14

// ==========================================================
// Field positions of crc_control_one
`define PCRC_BIT_MODULE_ON 15
`define PCRC_BIT_STOP_IN_IDLE 13
`define PCRC_FLD_COUNT_HI 12
`define PCRC_FLD_COUNT_LO 8
`define PCRC_BIT_FULL 7
`define PCRC_BIT_EMPTY 6
`define PCRC_BIT_IRQ_SEL 5
`define PCRC_BIT_RUN 4
`define PCRC_BIT_LSB_FIRST 3

// ==========================================================
// Field positions of crc_control_two
`define PCRC_FLD_DWIDTH_HI 12
`define PCRC_FLD_DWIDTH_LO 8
`define PCRC_FLD_PLEN_HI 4
`define PCRC_FLD_PLEN_LO 0

// ==========================================================
// Reset values and sizes
`define PCRC_RST_FIELD5 5'h00
`define PCRC_RST_POLY16 16'h0000
`define PCRC_RST_WORD 32'h0000_0000
`define PCRC_FIFO_DEPTH 16
`define PCRC_FIFO_DEPTH_LONG 8
`define PCRC_PLEN_SHORT_MAX 5'h07

`endif

//--- verilog/pcrc_pkg.sv
/*
 Types shared by the CRC generator modules.
 Assumes pcrc_map.svh is on the include path.
*/
`default_nettype none

package pcrc_pkg;
    typedef logic [31:0] pcrc_word_t;
    typedef logic [4:0] pcrc_field5_t;
    typedef enum logic [0:0] {PCRC_IDLE, PCRC_SHIFT} pcrc_state_t;
endpackage

`default_nettype wire

//--- verilog/pcrc_top.sv
/*
 Programmable CRC generator: APB register file, data FIFO and a serial
 shift engine folding one data bit per clock into a CRC of up to 32nd order.
 Assumes an APB master on pclk, a system idle indication synchronous to pclk,
 and a clock enable that freezes the whole block while low.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcrc_map.svh"

// Notes on behaviour
// - Polynomial length is the 5-bit length field plus one, up to 32.
// - Each set polynomial term bit up to the length field adds an XOR at that engine position; higher bits are ignored.
// - Zero-order term always applies; lowest low-term bit reads zero.
// - The Nth-order term is always implied; no storage bit for it.
// - Clearing module enable resets engine, FIFO pointers, data and result only.
// - Stop-in-idle set halts the engine and FIFO while the system idles; the bus still answers.
// - Read-only word count; capacity 8 when length field exceeds 7, else 16.
// - Read-only full and empty flags; empty resets to one, full to zero.
// - Interrupt select one: FIFO empty while last word shifts; zero: shift done.
// - Start bit runs the shifter consuming FIFO words; clearing stops it.
// - Endian bit one shifts LSB first, zero shifts MSB first.
module pcrc_top
    import pcrc_pkg::*;
#(
    parameter int FIFO_DEPTH = `PCRC_FIFO_DEPTH,
    parameter int FIFO_DEPTH_LONG = `PCRC_FIFO_DEPTH_LONG
) (
    // Clock, reset and enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // System power state
    input wire logic idle_mode,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Event output
    output logic crc_irq
);
    // ==========================================================
    // Declarations
    pcrc_fifo_if fifo ();

    logic module_on_reg;
    logic stop_in_idle_reg;
    logic irq_event_select_reg;
    logic shifter_run_reg;
    logic lsb_first_select_reg;
    pcrc_field5_t data_width_sel_reg;
    pcrc_field5_t poly_length_sel_reg;
    logic [15:0] poly_terms_high_reg;
    logic [15:1] poly_terms_low_reg;
    pcrc_word_t result_reg;
    pcrc_word_t result_next;
    pcrc_word_t shift_word_reg;
    pcrc_field5_t bit_idx_reg;
    pcrc_field5_t bits_left_reg;
    pcrc_state_t state_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic crc_irq_reg;

    logic active;
    logic setup;
    logic access_done;
    logic wr_done;
    logic hit_control_one;
    logic hit_control_two;
    logic hit_poly_high;
    logic hit_poly_low;
    logic hit_data;
    logic hit_result;
    logic mapped;
    logic [31:0] read_value;
    logic [31:0] poly_terms;
    logic data_bit;
    logic feedback;
    logic start_word;
    logic last_bit;
    logic shift_step;

    // ==========================================================
    // Enables
    // Halting in idle stops the engine and FIFO but not the bus
    assign active = clk_en && module_on_reg && !(stop_in_idle_reg && idle_mode);

    // ==========================================================
    // APB decode
    assign setup = psel && !penable;
    assign access_done = psel && penable && pready_reg;
    assign wr_done = access_done && pwrite && !pslverr_reg;

    always_comb begin
        hit_control_one = 1'b0;
        hit_control_two = 1'b0;
        hit_poly_high = 1'b0;
        hit_poly_low = 1'b0;
        hit_data = 1'b0;
        hit_result = 1'b0;
        if (paddr == `PCRC_OFS_CONTROL_ONE) begin
            hit_control_one = 1'b1;
        end else if (paddr == `PCRC_OFS_CONTROL_TWO) begin
            hit_control_two = 1'b1;
        end else if (paddr == `PCRC_OFS_POLY_HIGH) begin
            hit_poly_high = 1'b1;
        end else if (paddr == `PCRC_OFS_POLY_LOW) begin
            hit_poly_low = 1'b1;
        end else if (paddr == `PCRC_OFS_DATA_INPUT) begin
            hit_data = 1'b1;
        end else if (paddr == `PCRC_OFS_RESULT) begin
            hit_result = 1'b1;
        end
    end

    assign mapped = hit_control_one || hit_control_two || hit_poly_high || hit_poly_low || hit_data || hit_result;

    // ==========================================================
    // Read multiplexer
    always_comb begin
        read_value = 32'h0000_0000;
        if (hit_control_one) begin
            read_value[`PCRC_BIT_MODULE_ON] = module_on_reg;
            read_value[`PCRC_BIT_STOP_IN_IDLE] = stop_in_idle_reg;
            read_value[`PCRC_FLD_COUNT_HI:`PCRC_FLD_COUNT_LO] = fifo.count;
            read_value[`PCRC_BIT_FULL] = fifo.full;
            read_value[`PCRC_BIT_EMPTY] = fifo.empty;
            read_value[`PCRC_BIT_IRQ_SEL] = irq_event_select_reg;
            read_value[`PCRC_BIT_RUN] = shifter_run_reg;
            read_value[`PCRC_BIT_LSB_FIRST] = lsb_first_select_reg;
        end else if (hit_control_two) begin
            read_value[`PCRC_FLD_DWIDTH_HI:`PCRC_FLD_DWIDTH_LO] = data_width_sel_reg;
            read_value[`PCRC_FLD_PLEN_HI:`PCRC_FLD_PLEN_LO] = poly_length_sel_reg;
        end else if (hit_poly_high) begin
            read_value[15:0] = poly_terms_high_reg;
        end else if (hit_poly_low) begin
            read_value[15:1] = poly_terms_low_reg;
        end else if (hit_result) begin
            read_value = result_reg;
        end
    end

    // ==========================================================
    // APB answer: ready one cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
        end else if (clk_en) begin
            pready_reg <= setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_reg <= 1'b0;
        end else if (clk_en) begin
            pslverr_reg <= setup && !mapped;
        end
    end

    // Read data is captured at setup and stands through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= `PCRC_RST_WORD;
        end else if (clk_en && setup) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : read_value;
        end
    end

    // ==========================================================
    // Configuration registers, kept when the module is turned off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            module_on_reg <= 1'b0;
        end else if (clk_en && wr_done && hit_control_one) begin
            module_on_reg <= pwdata[`PCRC_BIT_MODULE_ON];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_in_idle_reg <= 1'b0;
            irq_event_select_reg <= 1'b0;
            shifter_run_reg <= 1'b0;
            lsb_first_select_reg <= 1'b0;
        end else if (clk_en && wr_done && hit_control_one) begin
            stop_in_idle_reg <= pwdata[`PCRC_BIT_STOP_IN_IDLE];
            irq_event_select_reg <= pwdata[`PCRC_BIT_IRQ_SEL];
            shifter_run_reg <= pwdata[`PCRC_BIT_RUN];
            lsb_first_select_reg <= pwdata[`PCRC_BIT_LSB_FIRST];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_width_sel_reg <= `PCRC_RST_FIELD5;
            poly_length_sel_reg <= `PCRC_RST_FIELD5;
        end else if (clk_en && wr_done && hit_control_two) begin
            data_width_sel_reg <= pwdata[`PCRC_FLD_DWIDTH_HI:`PCRC_FLD_DWIDTH_LO];
            poly_length_sel_reg <= pwdata[`PCRC_FLD_PLEN_HI:`PCRC_FLD_PLEN_LO];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            poly_terms_high_reg <= `PCRC_RST_POLY16;
        end else if (clk_en && wr_done && hit_poly_high) begin
            poly_terms_high_reg <= pwdata[15:0];
        end
    end

    // The zero-order bit has no storage, so it always reads back clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            poly_terms_low_reg <= 15'h0000;
        end else if (clk_en && wr_done && hit_poly_low) begin
            poly_terms_low_reg <= pwdata[15:1];
        end
    end

    // ==========================================================
    // FIFO hookup
    assign fifo.push = active && wr_done && hit_data;
    assign fifo.push_data = pwdata;
    assign fifo.flush = clk_en && !module_on_reg;
    // Shrinking the capacity keeps stored words; only further pushes are refused
    assign fifo.cap_short = (poly_length_sel_reg <= `PCRC_PLEN_SHORT_MAX);
    assign start_word = active && shifter_run_reg && (state_reg == PCRC_IDLE) && !fifo.empty;
    assign fifo.pop = start_word;

    pcrc_fifo #(
        .DEPTH(FIFO_DEPTH),
        .DEPTH_LONG(FIFO_DEPTH_LONG)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .fifo(fifo.store)
    );

    // ==========================================================
    // Shift engine datapath
    // Bit 0 is the always-present zero-order term
    assign poly_terms = {poly_terms_high_reg, poly_terms_low_reg, 1'b0};
    assign data_bit = shift_word_reg[bit_idx_reg];
    // Tap at the top of the selected length gives the implied Nth term
    assign feedback = data_bit ^ result_reg[poly_length_sel_reg];
    assign shift_step = active && shifter_run_reg && (state_reg == PCRC_SHIFT);
    assign last_bit = (bits_left_reg == 5'h00);

    generate
        for (genvar i = 0; i < 32; i++) begin : g_crc_bit
            if (i == 0) begin : g_low
                assign result_next[i] = feedback;
            end else begin : g_up
                // Positions above the polynomial length stay clear
                assign result_next[i] = (5'(i) <= poly_length_sel_reg) ?
                    (result_reg[i-1] ^ (feedback & poly_terms[i])) : 1'b0;
            end
        end
    endgenerate

    // ==========================================================
    // Shift engine sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= PCRC_IDLE;
            shift_word_reg <= `PCRC_RST_WORD;
            bit_idx_reg <= `PCRC_RST_FIELD5;
            bits_left_reg <= `PCRC_RST_FIELD5;
        end else if (clk_en) begin
            if (!module_on_reg) begin
                state_reg <= PCRC_IDLE;
                shift_word_reg <= `PCRC_RST_WORD;
                bit_idx_reg <= `PCRC_RST_FIELD5;
                bits_left_reg <= `PCRC_RST_FIELD5;
            end else if (start_word) begin
                state_reg <= PCRC_SHIFT;
                shift_word_reg <= fifo.pop_data;
                bit_idx_reg <= lsb_first_select_reg ? 5'h00 : data_width_sel_reg;
                bits_left_reg <= data_width_sel_reg;
            end else if (shift_step) begin
                if (last_bit) begin
                    state_reg <= PCRC_IDLE;
                end else begin
                    bits_left_reg <= bits_left_reg - 5'h01;
                    bit_idx_reg <= lsb_first_select_reg ? bit_idx_reg + 5'h01 : bit_idx_reg - 5'h01;
                end
            end
        end
    end

    // ==========================================================
    // Result register; a software write seeds it while no word shifts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= `PCRC_RST_WORD;
        end else if (clk_en) begin
            if (!module_on_reg) begin
                result_reg <= `PCRC_RST_WORD;
            end else if (shift_step) begin
                result_reg <= result_next;
            end else if (wr_done && hit_result && state_reg == PCRC_IDLE) begin
                result_reg <= pwdata;
            end
        end
    end

    // ==========================================================
    // Event pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_irq_reg <= 1'b0;
        end else if (clk_en) begin
            if (irq_event_select_reg) begin
                // Last word leaves the FIFO and starts shifting
                crc_irq_reg <= start_word && (fifo.count == 5'h01) && !fifo.push;
            end else begin
                // Final bit applied with nothing left to shift
                crc_irq_reg <= shift_step && last_bit && fifo.empty;
            end
        end
    end

    // ==========================================================
    // Outputs
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign crc_irq = crc_irq_reg;
endmodule // pcrc_top

`default_nettype wire
